// ===== include/ppd_pkg.sv
// Constants, register map and types for the pick-up and delay element
package ppd_pkg;
  localparam int          ADDR_W        = 8;
  localparam int          DATA_W        = 32;
  localparam int          MAG_W         = 24;
  localparam int          LVL_W         = 16;
  localparam int          NOM_W         = 8;
  localparam int          DLY_W         = 19;
  localparam int          CNT_W         = 24;
  localparam int          ACC_W         = 32;
  localparam int          FLT_W         = 4;
  // Timing and hysteresis percentages
  localparam int          CLK_PERIOD_NS = 50;
  localparam int          CYCLE_NS      = 1000000;
  localparam int          CYCLE_CLKS    = CYCLE_NS / CLK_PERIOD_NS;
  localparam int          STEP_NS       = 5000000;
  localparam int          STEP_TICKS    = STEP_NS / CYCLE_NS;
  localparam int          BLK_LEAD_NS   = 5000000;
  localparam int          RELEASE_PCT   = 97;
  localparam int          FULL_PCT      = 100;
  localparam int          UNDER_REL_PCT = 103;
  // Register offsets
  localparam logic [7:0]  OFF_CTRL      = 8'h00;
  localparam logic [7:0]  OFF_PICKUP    = 8'h04;
  localparam logic [7:0]  OFF_NOMINAL   = 8'h08;
  localparam logic [7:0]  OFF_DELAY     = 8'h0C;
  localparam logic [7:0]  OFF_CURVE_IEC = 8'h10;
  localparam logic [7:0]  OFF_CURVE_IEE = 8'h14;
  localparam logic [7:0]  OFF_STATUS    = 8'h18;
  localparam logic [7:0]  OFF_IRQ_STAT  = 8'h1C;
  localparam logic [7:0]  OFF_IRQ_MASK  = 8'h20;
  localparam logic [7:0]  OFF_EVT_TIME  = 8'h24;
  localparam logic [7:0]  OFF_EVT_MAG   = 8'h28;
  localparam logic [7:0]  OFF_EVT_FAULT = 8'h2C;
  // Field positions
  localparam int          CTRL_INV_BIT  = 0;
  localparam int          CTRL_IEEE_BIT = 1;
  localparam int          CTRL_UNDER_BIT = 2;
  localparam int          IRQ_START_BIT = 0;
  localparam int          IRQ_BLK_BIT   = 1;
  localparam int          IRQ_TRIP_BIT  = 2;
  // Reset values
  localparam logic [2:0]  RST_CTRL      = 3'h0;
  localparam logic [15:0] RST_PICKUP    = 16'h0100;
  localparam logic [7:0]  RST_NOMINAL   = 8'h0A;
  localparam logic [18:0] RST_DELAY     = 19'h00008;
  localparam logic [31:0] RST_CURVE_IEC = 32'h0000_1000;
  localparam logic [31:0] RST_CURVE_IEE = 32'h0000_2000;
  localparam logic [2:0]  RST_IRQ_MASK  = 3'h0;

  typedef enum logic [1:0] {
    PPD_IDLE    = 2'b00,
    PPD_START   = 2'b01,
    PPD_TRIP    = 2'b11,
    PPD_BLOCKED = 2'b10
  } ppd_state_t;
endpackage : ppd_pkg

// ===== verilog/ppd_element.sv
// Protection pick-up, blocking and operate-delay element with register port
`timescale 1ns/1ps
module ppd_element #(
  parameter int CYCLE_CLKS_P = ppd_pkg::CYCLE_CLKS
) (
  input  wire logic                          ref_clk,
  input  wire logic                          rstn,
  input  wire logic [ppd_pkg::ADDR_W-1:0]    reg_addr,
  input  wire logic [ppd_pkg::DATA_W-1:0]    reg_wdata,
  input  wire logic                          reg_wr,
  input  wire logic                          reg_rd,
  output logic      [ppd_pkg::DATA_W-1:0]    reg_rdata,
  input  wire logic [ppd_pkg::MAG_W-1:0]     measured_magnitude,
  input  wire logic [ppd_pkg::FLT_W-1:0]     fault_type,
  input  wire logic                          block_in,
  output logic                               start_out,
  output logic                               blocked_out,
  output logic                               trip_out,
  output logic                               evt_valid,
  output logic      [ppd_pkg::CNT_W-1:0]     evt_time,
  output logic      [ppd_pkg::MAG_W-1:0]     evt_mag,
  output logic      [ppd_pkg::FLT_W-1:0]     evt_fault,
  output logic                               irq
);
  import ppd_pkg::*;

  function automatic logic hit(input logic [ADDR_W-1:0] a, input logic [7:0] off);
    hit = (a == off);
  endfunction : hit

  logic [CNT_W-1:0]   div_ff;
  logic               tick_ff;
  logic [2:0]         ctrl_ff;
  logic [LVL_W-1:0]   pickup_level_ff;
  logic [NOM_W-1:0]   nominal_ff;
  logic [DLY_W-1:0]   delay_ff;
  logic [ACC_W-1:0]   curve_iec_ff;
  logic [ACC_W-1:0]   curve_ieee_ff;
  logic [2:0]         irq_stat_ff;
  logic [2:0]         irq_mask_ff;
  ppd_state_t         state_ff;
  ppd_state_t         nxt_state;
  logic               pick_ff;
  logic               nxt_pick;
  logic [CNT_W-1:0]   cnt_ff;
  logic [CNT_W-1:0]   nxt_cnt;
  logic [ACC_W-1:0]   acc_ff;
  logic [ACC_W-1:0]   nxt_acc;
  logic [CNT_W-1:0]   stamp_ff;
  logic [MAG_W-1:0]   start_mag_ff;
  logic               blk_ff;
  logic               start_ff;
  logic               blocked_ff;
  logic               trip_ff;
  logic               evt_valid_ff;
  logic [CNT_W-1:0]   evt_time_ff;
  logic [MAG_W-1:0]   evt_mag_ff;
  logic [FLT_W-1:0]   evt_fault_ff;
  logic               irq_ff;
  logic [DATA_W-1:0]  rdata_ff;
  logic [31:0]        thr;
  logic [39:0]        mag_x100;
  logic [39:0]        thr_x97;
  logic [39:0]        thr_x100;
  logic [39:0]        thr_x103;
  logic [39:0]        mag_x97;
  logic [ACC_W-1:0]   excess;
  logic [ACC_W-1:0]   curve_lim;
  logic [CNT_W-1:0]   target;
  logic               inv_mode;
  logic               under_dir;
  logic               nxt_start;
  logic               nxt_blocked;
  logic               nxt_trip;
  logic [2:0]         ev;
  logic [2:0]         w1c;
  logic [2:0]         nxt_stat;
  logic [2:0]         nxt_mask;

  assign inv_mode  = ctrl_ff[CTRL_INV_BIT];
  assign under_dir = ctrl_ff[CTRL_UNDER_BIT];

  // Processing-cycle tick
  always_ff @(posedge ref_clk or negedge rstn) begin
    if (!rstn) begin
      div_ff  <= '0;
      tick_ff <= 1'b0;
    end else if (div_ff == CNT_W'(CYCLE_CLKS_P - 1)) begin
      div_ff  <= '0;
      tick_ff <= 1'b1;
    end else begin
      div_ff  <= div_ff + 1'b1;
      tick_ff <= 1'b0;
    end
  end

  // Settings registers
  always_ff @(posedge ref_clk or negedge rstn) begin
    if (!rstn) begin
      ctrl_ff         <= RST_CTRL;
      pickup_level_ff <= RST_PICKUP;
      nominal_ff      <= RST_NOMINAL;
      delay_ff        <= RST_DELAY;
      curve_iec_ff    <= RST_CURVE_IEC;
      curve_ieee_ff   <= RST_CURVE_IEE;
    end else if (reg_wr) begin
      if (hit(reg_addr, OFF_CTRL))      ctrl_ff         <= reg_wdata[2:0];
      if (hit(reg_addr, OFF_PICKUP))    pickup_level_ff <= reg_wdata[LVL_W-1:0];
      if (hit(reg_addr, OFF_NOMINAL))   nominal_ff      <= reg_wdata[NOM_W-1:0];
      if (hit(reg_addr, OFF_DELAY))     delay_ff        <= reg_wdata[DLY_W-1:0];
      if (hit(reg_addr, OFF_CURVE_IEC)) curve_iec_ff    <= reg_wdata;
      if (hit(reg_addr, OFF_CURVE_IEE)) curve_ieee_ff   <= reg_wdata;
    end
  end

  assign thr      = 32'(pickup_level_ff) * 32'(nominal_ff);
  assign mag_x100 = 40'(measured_magnitude) * 40'(FULL_PCT);
  assign mag_x97  = 40'(measured_magnitude) * 40'(RELEASE_PCT);
  assign thr_x97  = 40'(thr) * 40'(RELEASE_PCT);
  assign thr_x100 = 40'(thr) * 40'(FULL_PCT);
  assign thr_x103 = 40'(thr) * 40'(UNDER_REL_PCT);

  // Pick-up comparison with fixed release hysteresis
  always_comb begin
    nxt_pick = pick_ff;
    if (!under_dir) begin
      if (!pick_ff && (measured_magnitude > MAG_W'(thr)) && (thr[31:MAG_W] == '0))
        nxt_pick = 1'b1;
      else if (pick_ff && (mag_x100 < thr_x97))
        nxt_pick = 1'b0;
    end else begin
      if (!pick_ff && (mag_x100 < thr_x100))
        nxt_pick = 1'b1;
      else if (pick_ff && (mag_x100 > thr_x103) && (mag_x97 > '0))
        nxt_pick = 1'b0;
    end
  end

  // Excess over level feeds inverse integrator; series selects limit
  assign excess    = (measured_magnitude > MAG_W'(thr)) ? ACC_W'(measured_magnitude) - thr : '0;
  assign curve_lim = ctrl_ff[CTRL_IEEE_BIT] ? curve_ieee_ff : curve_iec_ff;
  // Delay steps converted to processing cycles
  assign target    = CNT_W'(delay_ff) * CNT_W'(STEP_TICKS);

  // Blocking taken from the tick that opens the cycle
  always_comb begin
    nxt_state   = state_ff;
    nxt_start   = 1'b0;
    nxt_blocked = 1'b0;
    nxt_trip    = 1'b0;
    nxt_cnt     = '0;
    nxt_acc     = '0;
    // Blocked pick-up stops processing; release path clears timer
    if (nxt_pick && block_in) begin
      nxt_state   = PPD_BLOCKED;
      nxt_blocked = 1'b1;
    end else if (nxt_pick) begin
      nxt_start = 1'b1;
      nxt_cnt   = start_ff ? cnt_ff + 1'b1 : '0;
      nxt_acc   = start_ff ? acc_ff + excess : excess;
      // Mode select, fixed delay, zero means instant
      if (!inv_mode)
        nxt_trip = (nxt_cnt >= target);
      else
        // Fixed delay is lower bound in inverse mode
        nxt_trip = (nxt_acc >= curve_lim) && (nxt_cnt >= target);
      if (trip_ff)
        nxt_trip = 1'b1;
      nxt_state = nxt_trip ? PPD_TRIP : PPD_START;
    end else begin
      nxt_state = PPD_IDLE;
    end
  end

  // Element state, updated once per processing cycle
  always_ff @(posedge ref_clk or negedge rstn) begin
    if (!rstn) begin
      state_ff   <= PPD_IDLE;
      pick_ff    <= 1'b0;
      blk_ff     <= 1'b0;
      start_ff   <= 1'b0;
      blocked_ff <= 1'b0;
      trip_ff    <= 1'b0;
      cnt_ff     <= '0;
      acc_ff     <= '0;
    end else if (tick_ff) begin
      state_ff   <= nxt_state;
      pick_ff    <= nxt_pick;
      blk_ff     <= block_in;
      start_ff   <= nxt_start;
      blocked_ff <= nxt_blocked;
      trip_ff    <= nxt_trip;
      cnt_ff     <= nxt_cnt;
      acc_ff     <= nxt_acc;
    end
  end

  // Time base and magnitude captured at pick-up
  always_ff @(posedge ref_clk or negedge rstn) begin
    if (!rstn) begin
      stamp_ff     <= '0;
      start_mag_ff <= '0;
    end else if (tick_ff) begin
      stamp_ff <= stamp_ff + 1'b1;
      if (nxt_pick && !pick_ff)
        start_mag_ff <= measured_magnitude;
    end
  end

  always_ff @(posedge ref_clk or negedge rstn) begin
    if (!rstn) begin
      evt_valid_ff <= 1'b0;
      evt_time_ff  <= '0;
      evt_mag_ff   <= '0;
      evt_fault_ff <= '0;
    end else begin
      evt_valid_ff <= 1'b0;
      if (tick_ff && nxt_blocked && !blocked_ff) begin
        evt_valid_ff <= 1'b1;
        evt_time_ff  <= stamp_ff;
        evt_mag_ff   <= (nxt_pick && !pick_ff) ? measured_magnitude : start_mag_ff;
        evt_fault_ff <= fault_type;
      end
    end
  end

  // Interrupt status, set wins over write-one clear
  assign ev[IRQ_START_BIT] = tick_ff && nxt_start && !start_ff;
  assign ev[IRQ_BLK_BIT]   = tick_ff && nxt_blocked && !blocked_ff;
  assign ev[IRQ_TRIP_BIT]  = tick_ff && nxt_trip && !trip_ff;
  assign w1c      = (reg_wr && hit(reg_addr, OFF_IRQ_STAT)) ? reg_wdata[2:0] : 3'h0;
  assign nxt_stat = (irq_stat_ff & ~w1c) | ev;
  assign nxt_mask = (reg_wr && hit(reg_addr, OFF_IRQ_MASK)) ? reg_wdata[2:0] : irq_mask_ff;

  always_ff @(posedge ref_clk or negedge rstn) begin
    if (!rstn) begin
      irq_stat_ff <= 3'h0;
      irq_mask_ff <= RST_IRQ_MASK;
      irq_ff      <= 1'b0;
    end else begin
      irq_stat_ff <= nxt_stat;
      irq_mask_ff <= nxt_mask;
      irq_ff      <= |(nxt_stat & nxt_mask);
    end
  end

  // Read port, data valid only in the cycle after the strobe
  always_ff @(posedge ref_clk or negedge rstn) begin
    if (!rstn) begin
      rdata_ff <= '0;
    end else begin
      rdata_ff <= '0;
      if (reg_rd) begin
        case (reg_addr)
          OFF_CTRL:      rdata_ff <= DATA_W'(ctrl_ff);
          OFF_PICKUP:    rdata_ff <= DATA_W'(pickup_level_ff);
          OFF_NOMINAL:   rdata_ff <= DATA_W'(nominal_ff);
          OFF_DELAY:     rdata_ff <= DATA_W'(delay_ff);
          OFF_CURVE_IEC: rdata_ff <= curve_iec_ff;
          OFF_CURVE_IEE: rdata_ff <= curve_ieee_ff;
          OFF_STATUS:    rdata_ff <= DATA_W'({state_ff, blk_ff, pick_ff, trip_ff, blocked_ff, start_ff});
          OFF_IRQ_STAT:  rdata_ff <= DATA_W'(irq_stat_ff);
          OFF_IRQ_MASK:  rdata_ff <= DATA_W'(irq_mask_ff);
          OFF_EVT_TIME:  rdata_ff <= DATA_W'(evt_time_ff);
          OFF_EVT_MAG:   rdata_ff <= DATA_W'(evt_mag_ff);
          OFF_EVT_FAULT: rdata_ff <= DATA_W'(evt_fault_ff);
          default:       rdata_ff <= '0;
        endcase
      end
    end
  end

  assign reg_rdata   = rdata_ff;
  assign start_out   = start_ff;
  assign blocked_out = blocked_ff;
  assign trip_out    = trip_ff;
  assign evt_valid   = evt_valid_ff;
  assign evt_time    = evt_time_ff;
  assign evt_mag     = evt_mag_ff;
  assign evt_fault   = evt_fault_ff;
  assign irq         = irq_ff;

  default clocking cb @(posedge ref_clk); endclocking
  default disable iff (!rstn);

  a_trip_needs_start: assert property (trip_ff |-> start_ff)
    else $error("trip without start");
  a_start_blk_excl: assert property (!(start_ff && blocked_ff))
    else $error("start and blocked together");
  a_instant_trip: assert property ($rose(start_ff) && delay_ff == '0 && !inv_mode |-> trip_ff)
    else $error("instant trip missing");
  a_delay_bound: assert property (trip_ff |-> cnt_ff >= target)
    else $error("trip before delay");
  a_block_clears: assert property (tick_ff && block_in |=> !start_ff && !trip_ff)
    else $error("blocking left start active");
  a_block_event: assert property ($rose(blocked_ff) |-> evt_valid_ff ##1 !evt_valid_ff)
    else $error("blocking event missing");
  a_cycle_update: assert property (!$past(tick_ff) |-> $stable(start_ff) && $stable(trip_ff))
    else $error("state moved off tick");
  a_restart_zero: assert property ($rose(start_ff) |-> cnt_ff == '0)
    else $error("timer not restarted");
  a_irq_level: assert property (irq_ff == |(irq_stat_ff & irq_mask_ff))
    else $error("irq mismatch");
  a_read_slot: assert property (!$past(reg_rd) |-> rdata_ff == '0)
    else $error("read data outside slot");
endmodule : ppd_element

// ===== test/ppd_front.sv
// Behavioural measurement front end and blocking matrix source
`timescale 1ns/1ps
module ppd_front (
  input  wire logic                     ref_clk,
  input  wire logic [ppd_pkg::MAG_W-1:0] mag_cmd,
  input  wire logic                     blk_cmd,
  input  wire logic [ppd_pkg::FLT_W-1:0] flt_cmd,
  output logic      [ppd_pkg::MAG_W-1:0] measured_magnitude,
  output logic                          block_in,
  output logic      [ppd_pkg::FLT_W-1:0] fault_type
);
  import ppd_pkg::*;
  // Digitised samples arrive one clock after the bench asks for them
  always_ff @(posedge ref_clk) begin
    measured_magnitude <= mag_cmd;
    fault_type         <= flt_cmd;
  end
  // registered blocking source
  // Blocking follows the bench command one clock later, with no lead over delay expiry
  always_ff @(posedge ref_clk) begin
    block_in <= blk_cmd;
  end
endmodule : ppd_front

// ===== test/tb.sv
// Self-checking bench for the pick-up and delay element
`timescale 1ns/1ps
module tb;
  import ppd_pkg::*;
  localparam int N = 8;
  logic              ref_clk   = 1'b0;
  logic              rstn      = 1'b0;
  logic              reg_wr    = 1'b0;
  logic              reg_rd    = 1'b0;
  logic              blk_cmd   = 1'b0;
  logic [ADDR_W-1:0] reg_addr  = '0;
  logic [DATA_W-1:0] reg_wdata = '0;
  logic [MAG_W-1:0]  mag_cmd   = '0;
  logic [FLT_W-1:0]  flt_cmd   = '0;
  logic [DATA_W-1:0] reg_rdata, rv;
  logic [MAG_W-1:0]  measured_magnitude, evt_mag;
  logic [CNT_W-1:0]  evt_time;
  logic [FLT_W-1:0]  fault_type, evt_fault;
  logic              block_in, start_out, blocked_out, trip_out, evt_valid, irq, e;
  int                fails = 0;
  int                compares = 0;
  int                n;
  int                cyc = 0;
  logic [7:0]        ra [8] = '{OFF_CTRL, OFF_PICKUP, OFF_NOMINAL, OFF_DELAY, OFF_CURVE_IEC,
                                OFF_CURVE_IEE, OFF_IRQ_MASK, 8'h30};
  logic [31:0]       rx [8] = '{32'(RST_CTRL), 32'(RST_PICKUP), 32'(RST_NOMINAL), 32'(RST_DELAY),
                                RST_CURVE_IEC, RST_CURVE_IEE, 32'(RST_IRQ_MASK), 32'h0};
  int                iv [3][3] = '{'{1, 0, 2}, '{1, 1, 5}, '{3, 0, 1}};

  always #25 ref_clk = ~ref_clk;
  always @(posedge ref_clk) cyc <= cyc + 1;

  ppd_element #(.CYCLE_CLKS_P(N)) u_ppd_element (.ref_clk(ref_clk), .rstn(rstn), .reg_addr(reg_addr),
    .reg_wdata(reg_wdata), .reg_wr(reg_wr), .reg_rd(reg_rd), .reg_rdata(reg_rdata),
    .measured_magnitude(measured_magnitude), .fault_type(fault_type), .block_in(block_in),
    .start_out(start_out), .blocked_out(blocked_out), .trip_out(trip_out), .evt_valid(evt_valid),
    .evt_time(evt_time), .evt_mag(evt_mag), .evt_fault(evt_fault), .irq(irq));
  ppd_front u_ppd_front (.ref_clk(ref_clk), .mag_cmd(mag_cmd), .blk_cmd(blk_cmd), .flt_cmd(flt_cmd),
    .measured_magnitude(measured_magnitude), .block_in(block_in), .fault_type(fault_type));

  task automatic complete_run();
    $display("compares %0d fails %0d", compares, fails);
    if (fails == 0 && compares > 0) begin
      $display("STATUS OK");
    end else begin
      $display("STATUS NOT OK");
    end
    $finish;
  endtask : complete_run

  task automatic check(input string what, input logic [31:0] seen, input logic [31:0] exp);
    compares++;
    if (seen !== exp) begin
      fails++;
      $display("CHECK FAILED %s expected %0h seen %0h", what, exp, seen);
    end
  endtask : check

  task automatic idle(input int c);
    repeat (c) @(posedge ref_clk);
  endtask : idle

  task automatic wr(input logic [7:0] a, input logic [31:0] d);
    @(posedge ref_clk);
    reg_wr    <= 1'b1;
    reg_addr  <= a;
    reg_wdata <= d;
    @(posedge ref_clk);
    reg_wr    <= 1'b0;
  endtask : wr

  task automatic rd(input logic [7:0] a, output logic [31:0] d);
    @(posedge ref_clk);
    reg_rd   <= 1'b1;
    reg_addr <= a;
    @(posedge ref_clk);
    reg_rd   <= 1'b0;
    @(posedge ref_clk);
    d = reg_rdata;
  endtask : rd

  function automatic logic sig(input int w);
    case (w)
      0: return start_out;
      1: return trip_out;
      2: return blocked_out;
      default: return evt_valid;
    endcase
  endfunction : sig

  // Expected start after one tick with hysteresis around a level of 16
  function automatic logic nxt_pick(input logic st, input int m);
    return st ? !(m * FULL_PCT < 16 * RELEASE_PCT) : (m > 16);
  endfunction : nxt_pick

  task automatic wait_sig(input int w, output int c);
    c = 0;
    while (sig(w) !== 1'b1 && c < 2000) begin
      @(posedge ref_clk);
      c++;
    end
    if (c >= 2000) begin
      fails++;
      complete_run();
    end
  endtask : wait_sig

  task automatic drop();
    mag_cmd <= '0;
    blk_cmd <= 1'b0;
    idle(N + 3);
    check("start", start_out, 1'b0);
  endtask : drop

  initial begin
    void'($urandom(6));
    idle(10);
    rstn <= 1'b1;
    for (int i = 0; i < 8; i++) begin
      rd(ra[i], rv);
      check("reg", rv, rx[i]);
    end
    wr(OFF_STATUS, 32'hFF);
    rd(OFF_STATUS, rv);
    check("status", rv, 32'h0);
    mag_cmd <= 24'd3000;
    wait_sig(0, n);
    wait_sig(1, n);
    check("dflt delay", n, STEP_TICKS * int'(RST_DELAY) * N);
    check("irq masked", irq, 1'b0);
    rd(OFF_IRQ_STAT, rv);
    check("irq stat", rv, 32'h5);
    wr(OFF_IRQ_MASK, 32'h7);
    idle(2);
    check("irq on", irq, 1'b1);
    wr(OFF_IRQ_STAT, 32'h5);
    idle(2);
    check("irq off", irq, 1'b0);
    wr(OFF_PICKUP, 32'h8);
    wr(OFF_NOMINAL, 32'h2);
    mag_cmd <= 24'd16;
    idle(N + 3);
    check("hold", {start_out, trip_out}, 2'b11);
    mag_cmd <= 24'd15;
    idle(N + 3);
    check("release", {start_out, trip_out}, 2'b00);
    wr(OFF_DELAY, 32'h0);
    mag_cmd <= 24'd20;
    wait_sig(0, n);
    wait_sig(1, n);
    check("instant", n, 0);
    drop();
    wr(OFF_DELAY, 32'h1);
    mag_cmd <= 24'd20;
    wait_sig(0, n);
    idle(3 * N);
    drop();
    mag_cmd <= 24'd20;
    wait_sig(0, n);
    wait_sig(1, n);
    check("restart", n, STEP_TICKS * N);
    drop();
    blk_cmd <= 1'b1;
    flt_cmd <= 4'hA;
    mag_cmd <= 24'd21;
    wait_sig(3, n);
    // Element acts on clock 11+N after start, then every N
    check("evt time", evt_time, (cyc - 11 - N) / N);
    check("evt fault", evt_fault, 4'hA);
    check("evt mag", evt_mag, 24'd21);
    idle(2);
    check("blocked", {blocked_out, start_out, trip_out}, 3'b100);
    drop();
    wr(OFF_IRQ_STAT, 32'h7);
    wr(OFF_DELAY, 32'h2);
    mag_cmd <= 24'd20;
    wait_sig(0, n);
    blk_cmd <= 1'b1;
    wait_sig(3, n);
    check("evt mag2", evt_mag, 24'd20);
    idle(2);
    check("blk clr", {start_out, trip_out}, 2'b00);
    rd(OFF_IRQ_STAT, rv);
    check("blk irq", rv[IRQ_BLK_BIT], 1'b1);
    check("blk stat", rv, 32'h3);
    check("blk line", irq, 1'b1);
    drop();
    wr(OFF_CURVE_IEC, 32'd30);
    wr(OFF_CURVE_IEE, 32'd20);
    for (int i = 0; i < 3; i++) begin
      wr(OFF_CTRL, iv[i][0]);
      wr(OFF_DELAY, iv[i][1]);
      mag_cmd <= 24'd26;
      wait_sig(0, n);
      wait_sig(1, n);
      check("inverse", n, iv[i][2] * N);
      drop();
    end
    wr(OFF_CTRL, 32'h0);
    wr(OFF_DELAY, 32'h0);
    e = 1'b0;
    repeat (24) begin
      n = $urandom_range(12, 20);
      mag_cmd <= n[MAG_W-1:0];
      idle(N + 3);
      e = nxt_pick(e, n);
      check("rand pick", {start_out, trip_out}, {e, e});
    end
    wr(OFF_CTRL, 32'h4);
    mag_cmd <= 24'd10;
    idle(N + 3);
    check("under pick", {start_out, trip_out}, 2'b11);
    mag_cmd <= 24'd16;
    idle(N + 3);
    check("under hold", {start_out, trip_out}, 2'b11);
    mag_cmd <= 24'd17;
    idle(N + 3);
    check("under rel", {start_out, trip_out}, 2'b00);
    complete_run();
  end
endmodule : tb
